// >>> core/mfc_fault_classifier.v
// Memory-management fault classifier with an AHB-Lite register slave
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mfc_defines.vh"

module mfc_fault_classifier #(
	parameter CNT_W = 16,
	parameter PSW_W = 4
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             hsel,
	input  wire [31:0]      haddr,
	input  wire [1:0]       htrans,
	input  wire             hwrite,
	input  wire [2:0]       hsize,
	input  wire [31:0]      hwdata,
	input  wire             hready,
	output reg  [31:0]      hrdata,
	output reg              hreadyout,
	output reg              hresp,
	input  wire             req_valid,
	input  wire [1:0]       req_kind,
	input  wire [1:0]       req_seg,
	input  wire [7:0]       pte1_flags,
	input  wire [7:0]       pte2_flags,
	input  wire [7:0]       pte3_flags,
	input  wire [PSW_W-1:0] processor_status_word,
	output reg              resp_valid,
	output reg              fault_valid,
	output reg  [2:0]       fault_type_code
);

	// Classification of the current reference
	wire            user_mode;
	wire            l1_stop;
	wire [2:0]      l1_code;
	wire            l2_stop;
	wire [2:0]      l2_code;
	wire            l3_invalid;
	wire            l3_denied;
	wire            l3_flag_hit;
	wire [2:0]      l3_flag_code;
	reg             walk_fault;
	reg             flag_fault;
	reg  [2:0]      walk_code;
	reg  [2:0]      flag_code;
	reg             any_fault;
	reg  [2:0]      any_code;

	// Register state
	reg             enable_q;
	reg  [2:0]      last_code_q;
	reg             last_valid_q;
	reg             sticky_q;
	reg  [CNT_W-1:0] count_q;
	reg  [CNT_W-1:0] count_d;
	reg             sticky_d;

	// Bus data phase
	reg             wr_pend_q;
	reg  [7:0]      wr_addr_q;
	reg  [31:0]     rd_data;
	wire            bus_take;
	wire            wr_data;
	wire            clr_count;
	wire            clr_sticky;
	wire            ctrl_wr;

	assign user_mode = (processor_status_word[`MFC_PSW_MODE_BIT] == `MFC_MODE_USER); // see R10

	// One checker per walk level; the two upper levels share one rule set
	mfc_upper_check #(
		.PTE_W (8)
	) u_level1 (
		.pte_flags (pte1_flags),
		.stop      (l1_stop),
		.code      (l1_code)
	);

	mfc_upper_check #(
		.PTE_W (8)
	) u_level2 (
		.pte_flags (pte2_flags),
		.stop      (l2_stop),
		.code      (l2_code)
	);

	mfc_leaf_check #(
		.PTE_W (8)
	) u_level3 (
		.pte_flags (pte3_flags),
		.req_kind  (req_kind),
		.user_mode (user_mode),
		.invalid   (l3_invalid),
		.denied    (l3_denied),
		.flag_hit  (l3_flag_hit),
		.flag_code (l3_flag_code)
	);

	always @* begin
		walk_fault = 1'b0;
		walk_code  = `MFC_CODE_TNV;
		flag_fault = 1'b0;
		flag_code  = `MFC_CODE_FOR;
		if (req_seg == `MFC_SEG_KERNEL) begin
			if (user_mode) begin
				walk_fault = 1'b1;
				walk_code  = `MFC_CODE_ACV; // see R5
			end
		end else if ((req_seg == `MFC_SEG_USER_LOW) || (req_seg == `MFC_SEG_USER_HIGH)) begin
			if (l1_stop) begin
				walk_fault = 1'b1;
				walk_code  = l1_code;
			end else if (l2_stop) begin
				walk_fault = 1'b1;
				walk_code  = l2_code;
			end else if (l3_invalid) begin
				walk_fault = 1'b1;
				walk_code  = `MFC_CODE_TNV; // see R2
			end else if (l3_denied) begin
				// Upper-level protection bits are not consulted here
				walk_fault = 1'b1; // see R11
				walk_code  = `MFC_CODE_ACV; // see R3
			end
			flag_fault = l3_flag_hit;
			flag_code  = l3_flag_code;
		end
		// A walk fault hides any fault-on bit of the same reference
		any_fault = walk_fault || flag_fault;
		any_code  = walk_fault ? walk_code : flag_code; // see R12
	end

	// Result presented one cycle after the request
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_valid      <= 1'b0;
			fault_valid     <= 1'b0;
			fault_type_code <= 3'h0;
		end else begin
			resp_valid  <= req_valid;
			fault_valid <= req_valid && enable_q && any_fault;
			if (req_valid && enable_q && any_fault)
				fault_type_code <= any_code; // see R1
		end
	end

	assign bus_take   = hsel && htrans[1] && hready;
	assign wr_data    = wr_pend_q;
	assign ctrl_wr    = wr_data && (wr_addr_q == `MFC_OFS_CTRL);
	assign clr_count  = ctrl_wr && hwdata[`MFC_CTRL_CLR_COUNT];
	assign clr_sticky = wr_data && (wr_addr_q == `MFC_OFS_STATUS) && hwdata[`MFC_STAT_STICKY];

	wire            new_fault;
	assign new_fault  = req_valid && enable_q && any_fault;

	// A fault in the clearing cycle is kept: set wins over clear
	always @* begin
		count_d = count_q;
		if (clr_count)
			count_d = {CNT_W{1'b0}};
		if (new_fault) begin
			if (clr_count)
				count_d = {{(CNT_W-1){1'b0}}, 1'b1};
			else if (count_q != {CNT_W{1'b1}})
				count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		sticky_d = sticky_q;
		if (clr_sticky)
			sticky_d = 1'b0;
		if (new_fault)
			sticky_d = 1'b1;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_q     <= `MFC_RST_ENABLE;
			last_code_q  <= 3'h0;
			last_valid_q <= 1'b0;
			sticky_q     <= 1'b0;
			count_q      <= {CNT_W{1'b0}};
		end else begin
			if (ctrl_wr)
				enable_q <= hwdata[`MFC_CTRL_ENABLE];
			if (new_fault) begin
				last_code_q  <= any_code;
				last_valid_q <= 1'b1;
			end
			sticky_q <= sticky_d;
			count_q  <= count_d;
		end
	end

	// Read data for the address being taken, so hrdata comes from a flop
	always @* begin
		rd_data = 32'h0000_0000;
		if (haddr[7:0] == `MFC_OFS_CTRL) begin
			rd_data[`MFC_CTRL_ENABLE] = enable_q;
		end else if (haddr[7:0] == `MFC_OFS_STATUS) begin
			rd_data[2:0]              = last_code_q;
			rd_data[3]                = last_valid_q;
			rd_data[`MFC_STAT_STICKY] = sticky_q;
		end else if (haddr[7:0] == `MFC_OFS_COUNT) begin
			rd_data[CNT_W-1:0] = count_q;
		end
		if (haddr[31:8] != 24'h00_0000)
			rd_data = 32'h0000_0000;
	end

	// Zero-wait slave: every transfer completes with OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= bus_take && hwrite && (haddr[31:8] == 24'h00_0000) &&
				(hsize == 3'h2);
			if (bus_take) begin
				wr_addr_q <= haddr[7:0];
				if (!hwrite)
					hrdata <= rd_data;
			end
		end
	end

endmodule

// Verdict on one upper-level walk entry: an invalid entry stops the walk
module mfc_upper_check #(
	parameter PTE_W = 8
) (
	input  wire [PTE_W-1:0] pte_flags,
	output reg              stop,
	output reg  [2:0]       code
);

	always @* begin
		stop = 1'b0;
		code = `MFC_CODE_TNV;
		if (!pte_flags[`MFC_PTE_VALID]) begin
			stop = 1'b1; // see R2
			// Without kernel read enable the invalid entry gives an access violation
			if (!pte_flags[`MFC_PTE_KRE])
				code = `MFC_CODE_ACV; // see R4
			else
				code = `MFC_CODE_TNV;
		end
	end

endmodule

// Verdict on the last-level entry: protection by mode, then the fault-on bits
module mfc_leaf_check #(
	parameter PTE_W = 8
) (
	input  wire [PTE_W-1:0] pte_flags,
	input  wire [1:0]       req_kind,
	input  wire             user_mode,
	output reg              invalid,
	output reg              denied,
	output reg              flag_hit,
	output reg  [2:0]       flag_code
);

	reg             is_read;
	reg             is_write;

	always @* begin
		// Kind 3 is neither read nor write, so protection never refuses it
		is_read   = (req_kind == `MFC_KIND_LOAD) || (req_kind == `MFC_KIND_FETCH); // see R9
		is_write  = (req_kind == `MFC_KIND_STORE); // see R9
		invalid   = !pte_flags[`MFC_PTE_VALID];
		denied    = 1'b0;
		flag_hit  = 1'b0;
		flag_code = `MFC_CODE_FOR;
		if (user_mode) begin
			if ((is_write && !pte_flags[`MFC_PTE_UWE]) ||
				(is_read && !pte_flags[`MFC_PTE_URE]))
				denied = 1'b1; // see R10
		end else begin
			if ((is_write && !pte_flags[`MFC_PTE_KWE]) ||
				(is_read && !pte_flags[`MFC_PTE_KRE]))
				denied = 1'b1; // see R10
		end
		if (!invalid) begin
			if ((req_kind == `MFC_KIND_LOAD) && pte_flags[`MFC_PTE_FOR]) begin
				flag_hit  = 1'b1;
				flag_code = `MFC_CODE_FOR; // see R6
			end else if ((req_kind == `MFC_KIND_FETCH) && pte_flags[`MFC_PTE_FOE]) begin
				flag_hit  = 1'b1;
				flag_code = `MFC_CODE_FOE; // see R7
			end else if (is_write && pte_flags[`MFC_PTE_FOW]) begin
				flag_hit  = 1'b1;
				flag_code = `MFC_CODE_FOW; // see R8
			end
		end
	end

endmodule

// >>> core/mfc_defines.vh
// Constants for the memory-management fault classifier
// Notes on behaviour
// R1: Fault codes: 0 not valid, 1 access violation, 2 read, 3 execute, 4 write.
// R2: Invalid entry at walk level one, two or three gives translation-not-valid.
// R3: User segments: level-three protection bits forbidding the access give access violation.
// R4: Invalid level-one or level-two entry with kernel read enable clear: access violation.
// R5: Kernel direct-mapped segment accessed in user mode gives access violation.
// R6: Data read of a page with fault-on-read bit set gives code 2.
// R7: Instruction fetch of a page with fault-on-execute bit set gives code 3.
// R8: Data write of a page with fault-on-write bit set gives code 4.
// R9: Loads and fetches check as reads, stores check as writes.
// R10: Two modes, kernel and user, from the status mode field; enables per mode.
// R11: Valid level-one and level-two entries: protection ignored, level three decides.
// R12: Walk-level faults take priority over fault-on-read, execute or write.
`ifndef MFC_DEFINES_VH
`define MFC_DEFINES_VH

`define MFC_CODE_TNV        3'h0
`define MFC_CODE_ACV        3'h1
`define MFC_CODE_FOR        3'h2
`define MFC_CODE_FOE        3'h3
`define MFC_CODE_FOW        3'h4

`define MFC_KIND_LOAD       2'h0
`define MFC_KIND_STORE      2'h1
`define MFC_KIND_FETCH      2'h2

`define MFC_SEG_USER_LOW    2'h0
`define MFC_SEG_USER_HIGH   2'h1
`define MFC_SEG_KERNEL      2'h2

`define MFC_PTE_VALID       0
`define MFC_PTE_FOR         1
`define MFC_PTE_FOW         2
`define MFC_PTE_FOE         3
`define MFC_PTE_KRE         4
`define MFC_PTE_URE         5
`define MFC_PTE_KWE         6
`define MFC_PTE_UWE         7

`define MFC_PSW_MODE_BIT    3
`define MFC_MODE_USER       1'b1

`define MFC_OFS_CTRL        8'h00
`define MFC_OFS_STATUS      8'h04
`define MFC_OFS_COUNT       8'h08

`define MFC_CTRL_ENABLE     0
`define MFC_CTRL_CLR_COUNT  1
`define MFC_STAT_STICKY     8
`define MFC_RST_ENABLE      1'b1

`endif

// >>> tb/mfc_fault_classifier_asserts.sv
// Port-level property checker for the fault classifier
`timescale 1ns/1ps
module mfc_fault_classifier_asserts #(
	parameter PSW_W = 4
) (
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             req_valid,
	input wire logic [1:0]       req_kind,
	input wire logic [1:0]       req_seg,
	input wire logic [7:0]       pte1_flags,
	input wire logic [7:0]       pte2_flags,
	input wire logic [7:0]       pte3_flags,
	input wire logic [PSW_W-1:0] processor_status_word,
	input wire logic             resp_valid,
	input wire logic             fault_valid,
	input wire logic [2:0]       fault_type_code
);
	wire user = processor_status_word[3];
	wire useg = req_valid && !req_seg[1];
	wire allv = pte1_flags[0] && pte2_flags[0] && pte3_flags[0];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	resp_follow_a: assert property (req_valid |=> resp_valid)
		else $error("no response after request");
	code_range_a: assert property (fault_valid |-> resp_valid && fault_type_code <= 3'h4)
		else $error("fault code out of range");
	kseg_user_a: assert property (req_valid && req_seg == 2'h2 && user |=> fault_valid && fault_type_code == 3'h1)
		else $error("user access to kernel segment not refused");
	kseg_kern_a: assert property (req_valid && req_seg == 2'h2 && !user |=> !fault_valid)
		else $error("kernel access to kernel segment faulted");
	l1_noread_a: assert property (useg && !pte1_flags[0] && !pte1_flags[4] |=> fault_valid && fault_type_code == 3'h1)
		else $error("invalid first entry without read enable");
	l3_invalid_a: assert property (useg && pte1_flags[0] && pte2_flags[0] && !pte3_flags[0] |=> fault_valid && fault_type_code == 3'h0)
		else $error("invalid third entry not flagged");
	walk_first_a: assert property (fault_valid && fault_type_code >= 3'h2 |-> $past(allv))
		else $error("page fault bit reported over a walk fault");
	write_flag_a: assert property (useg && allv && req_kind == 2'h1 && pte3_flags[2] && (user ? pte3_flags[7] : pte3_flags[6]) |=> fault_valid && fault_type_code == 3'h4)
		else $error("write fault bit ignored");
	cover property (fault_valid && fault_type_code == 3'h2);
	cover property (fault_valid && fault_type_code == 3'h3);
	cover property (resp_valid && !fault_valid);
endmodule
bind mfc_fault_classifier mfc_fault_classifier_asserts #(.PSW_W(PSW_W)) u_mfc_chk (.hclk, .hresetn,
	.req_valid, .req_kind, .req_seg, .pte1_flags, .pte2_flags, .pte3_flags,
	.processor_status_word, .resp_valid, .fault_valid, .fault_type_code);

// >>> tb/mfc_walker_model.sv
// Stand-in for the table walker and pipeline that present references
`timescale 1ns/1ps
module mfc_walker_model (
	input  wire logic        hclk,
	input  wire logic        go,
	input  wire logic [28:0] ref_in,
	output logic             req_valid,
	output logic [1:0]       req_kind,
	output logic [1:0]       req_seg,
	output logic [7:0]       pte1_flags,
	output logic [7:0]       pte2_flags,
	output logic [7:0]       pte3_flags,
	output logic [3:0]       processor_status_word
);
	initial {req_valid, req_kind, req_seg, pte1_flags, pte2_flags, pte3_flags} = '0;
	initial processor_status_word = 4'h0;
	// Between references the walk data are stale, so they toggle instead of holding
	always @(posedge hclk) begin
		req_valid <= go;
		if (go)
			{processor_status_word[3], req_kind, req_seg, pte1_flags, pte2_flags, pte3_flags} <= ref_in;
		else
			{processor_status_word, req_kind, req_seg, pte1_flags, pte2_flags, pte3_flags} <= ~{processor_status_word, req_kind, req_seg, pte1_flags, pte2_flags, pte3_flags};
	end
endmodule

// >>> tb/test_mmu_fault_classifier.sv
// Bench for the fault classifier: references through the walker model, registers over AHB
`timescale 1ns/1ps
module test_mmu_fault_classifier;
	localparam logic [1:0] ld = 2'h0, st = 2'h1, fe = 2'h2;
	logic hclk, hresetn, hsel, hwrite, go, req_valid, resp_valid, fault_valid, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, req_kind, req_seg;
	logic [7:0] pte1_flags, pte2_flags, pte3_flags;
	logic [3:0] processor_status_word;
	logic [2:0] fault_type_code;
	logic [28:0] ref_in;
	int n_mismatch, checks_done, nf, cyc;
	mfc_walker_model u_walk (.hclk(hclk), .go(go), .ref_in(ref_in), .req_valid(req_valid),
		.req_kind(req_kind), .req_seg(req_seg), .pte1_flags(pte1_flags), .pte2_flags(pte2_flags),
		.pte3_flags(pte3_flags), .processor_status_word(processor_status_word));
	mfc_fault_classifier dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
		.req_kind(req_kind), .req_seg(req_seg), .pte1_flags(pte1_flags), .pte2_flags(pte2_flags),
		.pte3_flags(pte3_flags), .processor_status_word(processor_status_word),
		.resp_valid(resp_valid), .fault_valid(fault_valid), .fault_type_code(fault_type_code));
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk(input logic [1:0] k, s, input logic [23:0] p, input logic m, v, input logic [2:0] c);
		@(posedge hclk);
		go <= 1'b1;
		ref_in <= {m, k, s, p};
		@(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
		#1;
		cmp("resp_valid", 32'h1, {31'h0, resp_valid});
		cmp("fault_valid", {31'h0, v}, {31'h0, fault_valid});
		if (v) begin
			cmp("fault_type_code", {29'h0, c}, {29'h0, fault_type_code});
			nf++;
		end
	endtask
	// The master waits on hready at both phase ends; only the timeout bounds it
	task ahb(input logic w, input logic [31:0] a, d, e);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		cmp("hresp", 32'h0, {31'h0, hresp});
		if (!w)
			cmp("hrdata", e, hrdata);
	endtask
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, go, htrans, haddr, hwdata, ref_in} = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		chk(ld, 2'h0, 24'h0101f1, 1'b1, 1'b0, 3'h0);
		chk(st, 2'h1, 24'h10f1f1, 1'b1, 1'b1, 3'h0);
		chk(ld, 2'h0, 24'hf110f1, 1'b1, 1'b1, 3'h0);
		chk(fe, 2'h0, 24'hf1f1f0, 1'b1, 1'b1, 3'h0);
		chk(ld, 2'h0, 24'h00f1f1, 1'b1, 1'b1, 3'h1);
		chk(st, 2'h1, 24'hf100f1, 1'b0, 1'b1, 3'h1);
		chk(st, 2'h0, 24'hf1f171, 1'b1, 1'b1, 3'h1);
		chk(st, 2'h0, 24'hf1f171, 1'b0, 1'b0, 3'h0);
		chk(fe, 2'h1, 24'hf1f1d1, 1'b1, 1'b1, 3'h1);
		chk(ld, 2'h0, 24'hf1f1e1, 1'b0, 1'b1, 3'h1);
		chk(ld, 2'h2, 24'h000000, 1'b1, 1'b1, 3'h1);
		chk(ld, 2'h2, 24'h000000, 1'b0, 1'b0, 3'h0);
		chk(ld, 2'h0, 24'hf1f1f3, 1'b1, 1'b1, 3'h2);
		chk(fe, 2'h0, 24'hf1f1f9, 1'b1, 1'b1, 3'h3);
		chk(st, 2'h1, 24'hf1f1f5, 1'b0, 1'b1, 3'h4);
		chk(ld, 2'h0, 24'hf1f1d3, 1'b1, 1'b1, 3'h1);
		$display("classifier test done");
		ahb(1'b0, 32'h00, 32'h0, 32'h1);
		ahb(1'b0, 32'h04, 32'h0, 32'h109);
		ahb(1'b0, 32'h08, 32'h0, nf);
		ahb(1'b0, 32'h40, 32'h0, 32'h0);
		ahb(1'b1, 32'h04, 32'h100, 32'h0);
		ahb(1'b0, 32'h04, 32'h0, 32'h9);
		chk(ld, 2'h3, 24'h000000, 1'b1, 1'b0, 3'h0);
		ahb(1'b1, 32'h00, 32'h0, 32'h0);
		chk(ld, 2'h0, 24'hf1f1f3, 1'b1, 1'b0, 3'h0);
		ahb(1'b0, 32'h08, 32'h0, nf);
		ahb(1'b1, 32'h00, 32'h3, 32'h0);
		ahb(1'b0, 32'h08, 32'h0, 32'h0);
		ahb(1'b0, 32'h00, 32'h0, 32'h1);
		$display("register test done");
		report_and_stop();
	end
endmodule
